// ==== rtl/anvs_defs.svh ====
// What this block does
// - Host keeps write strobe high throughout every read cycle.
// - Host holds the write interval at least 65 ns or 85 ns.
// - Host has address stable by write start, setup zero ns.
// - Host holds address valid 75 or 100 ns before write end.
// - Host keeps select low 75 or 100 ns before write end.
// - Host presents write data 35 or 45 ns before write end.
// - Host allows recovery 5 ns after write strobe or 15 ns after select.
// - Host holds data 0 ns after write strobe or 10 ns after select.
// - Read data valid 85 or 120 ns after select or address; cycle spacing. Reads sample the lines 100 ns after select, so only the 85 ns grade is met.
`ifndef ANVS_DEFS_SVH
`define ANVS_DEFS_SVH

`define ANVS_CLK_PERIOD_NS 50
`define ANVS_ADDR_W        18
`define ANVS_DATA_W        8

// Slow-grade figures in ns; writes meet both grades with them, but a read samples the lines 100 ns after select, so reads meet only the 85 ns grade.
`define ANVS_TWP_NS        85
`define ANVS_TCW_NS        100
`define ANVS_TDW_NS        45
`define ANVS_TWR_NS        15
`define ANVS_TDH_NS        10
`define ANVS_TAA_NS        120
`define ANVS_TOE_NS        60
`define ANVS_TCHZ_NS       45
`define ANVS_TRC_NS        120
`define ANVS_TCER_MS       120

// Least times round up.
`define ANVS_CYC_UP(ns) (((ns) + `ANVS_CLK_PERIOD_NS - 1) / `ANVS_CLK_PERIOD_NS)
`define ANVS_WR_CYC   `ANVS_CYC_UP(`ANVS_TCW_NS)
`define ANVS_RD_CYC   (`ANVS_CYC_UP(`ANVS_TAA_NS) + 1)
`define ANVS_REC_CYC  `ANVS_CYC_UP(`ANVS_TCHZ_NS)
`define ANVS_TCER_CYC (`ANVS_TCER_MS * 1000000 / `ANVS_CLK_PERIOD_NS)

`endif

// ==== rtl/anvs_pkg.sv ====
package anvs_pkg;
  typedef enum logic [2:0] {
    ANVS_IDLE  = 3'b000,
    ANVS_WSET  = 3'b001,
    ANVS_WPUL  = 3'b010,
    ANVS_WEND  = 3'b011,
    ANVS_RACC  = 3'b100,
    ANVS_REC   = 3'b101,
    ANVS_PROT  = 3'b110
  } anvs_state_t;
endpackage : anvs_pkg

// ==== rtl/anvs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module anvs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_r  <= '0;
      q_out <= '0;
    end else begin
      s1_r  <= d_in;
      q_out <= s1_r;
    end
  end
endmodule : anvs_sync
`default_nettype wire

// ==== rtl/anvs_host.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "anvs_defs.svh"
module anvs_host
  import anvs_pkg::*;
#(
  parameter int unsigned TCER_CYC = `ANVS_TCER_CYC
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    req_in,
  input  wire logic                    req_wr_in,
  input  wire logic [`ANVS_ADDR_W-1:0] req_addr_in,
  input  wire logic [`ANVS_DATA_W-1:0] req_wdata_in,
  input  wire logic                    supply_fail_in,
  output logic                         busy_out,
  output logic                         done_out,
  output logic [`ANVS_DATA_W-1:0]      rdata_out,
  output logic                         protected_out,
  output logic                         chip_sel_n_out,
  output logic                         write_n_out,
  output logic                         out_en_n_out,
  output logic [`ANVS_ADDR_W-1:0]      address_lines_out,
  output logic [`ANVS_DATA_W-1:0]      data_lines_out,
  output logic                         data_lines_oe_out,
  input  wire logic [`ANVS_DATA_W-1:0] data_lines_in
);
  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]              rst_sync_r;
  logic                    rst_n;
  logic                    fail_s;
  logic [`ANVS_DATA_W-1:0] rd_s;

  // The release is synchronised so that every register leaves reset on the same edge.
  // The data lines are sampled through the same two stages, so the byte taken one cycle
  // beyond the access time is the one that stood on the lines 100 ns after select.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  anvs_sync #(.W(1 + `ANVS_DATA_W)) u_sync (
    .clk_in  (ref_clk_in),
    .nrst_in (rst_n),
    .d_in    ({supply_fail_in, data_lines_in}),
    .q_out   ({fail_s, rd_s})
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    anvs_state_t             st;
    logic [31:0]             cnt;
    logic                    busy;
    logic                    done;
    logic [`ANVS_DATA_W-1:0] rdata;
    logic                    prot;
    logic                    cs_n;
    logic                    we_n;
    logic                    oe_n;
    logic [`ANVS_ADDR_W-1:0] addr;
    logic [`ANVS_DATA_W-1:0] wdata;
    logic                    doe;
  } anvs_regs_t;

  anvs_regs_t cur_r;
  anvs_regs_t cur_nxt;

  function automatic logic [31:0] cyc_less1(input int unsigned n);
    cyc_less1 = (n > 1) ? 32'(n - 1) : 32'h0;
  endfunction : cyc_less1

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // One counter serves every phase; it is wide enough for the whole
  // recovery period after a supply failure, at the cost of some area.
  always_comb begin
    cur_nxt      = cur_r;
    cur_nxt.done = 1'b0;
    case (cur_r.st)
      ANVS_IDLE: begin
        cur_nxt.busy = 1'b0;
        if (fail_s) begin
          // Pins are parked idle before protection, so nothing is cut short.
          // An access in flight always ends within a few cycles, far inside
          // the protect delay, so it is simply allowed to finish.
          cur_nxt.st   = ANVS_PROT;
          cur_nxt.prot = 1'b1;
          cur_nxt.busy = 1'b1;
          cur_nxt.cnt  = 32'h0;
        end else if (req_in) begin
          cur_nxt.busy = 1'b1;
          cur_nxt.addr = req_addr_in;
          if (req_wr_in) begin
            // Address and data settle a cycle before the strobes fall.
            cur_nxt.wdata = req_wdata_in;
            // Output strobe stays high through a write, so the memory
            // never drives against the data that the host puts out.
            cur_nxt.oe_n  = 1'b1;
            cur_nxt.st    = ANVS_WSET;
          end else begin
            cur_nxt.cs_n = 1'b0;
            cur_nxt.oe_n = 1'b0;
            cur_nxt.cnt  = cyc_less1(`ANVS_RD_CYC);
            cur_nxt.st   = ANVS_RACC;
          end
        end
      end
      ANVS_WSET: begin
        // Select and write strobe fall together, so the memory never
        // drives and data can be driven at once.
        cur_nxt.cs_n = 1'b0;
        cur_nxt.we_n = 1'b0;
        cur_nxt.doe  = 1'b1;
        cur_nxt.cnt  = cyc_less1(`ANVS_WR_CYC);
        cur_nxt.st   = ANVS_WPUL;
      end
      ANVS_WPUL: begin
        if (cur_r.cnt == 32'h0) begin
          // Write strobe rises first and ends the write.
          cur_nxt.we_n = 1'b1;
          cur_nxt.st   = ANVS_WEND;
        end else begin
          cur_nxt.cnt = cur_r.cnt - 32'h1;
        end
      end
      ANVS_WEND: begin
        // Data and select held a full cycle past the write end.
        // The output strobe is still high here, so the memory does not
        // start driving when the write ends.
        cur_nxt.cs_n = 1'b1;
        cur_nxt.doe  = 1'b0;
        cur_nxt.cnt  = cyc_less1(`ANVS_REC_CYC);
        cur_nxt.done = 1'b1;
        cur_nxt.st   = ANVS_REC;
      end
      ANVS_RACC: begin
        if (cur_r.cnt == 32'h0) begin
          cur_nxt.rdata = rd_s;
          cur_nxt.cs_n  = 1'b1;
          cur_nxt.oe_n  = 1'b1;
          cur_nxt.done  = 1'b1;
          cur_nxt.cnt   = cyc_less1(`ANVS_REC_CYC);
          cur_nxt.st    = ANVS_REC;
        end else begin
          cur_nxt.cnt = cur_r.cnt - 32'h1;
        end
      end
      ANVS_REC: begin
        // Gap lets the memory float its lines before the next cycle.
        if (cur_r.cnt == 32'h0) begin
          cur_nxt.st = ANVS_IDLE;
        end else begin
          cur_nxt.cnt = cur_r.cnt - 32'h1;
        end
      end
      ANVS_PROT: begin
        cur_nxt.cs_n = 1'b1;
        cur_nxt.doe  = 1'b0;
        // A fresh failure restarts the recovery count from zero.
        if (fail_s) begin
          cur_nxt.cnt = 32'h0;
        end else if (cur_r.cnt >= 32'(TCER_CYC) - 32'h1) begin
          cur_nxt.st   = ANVS_IDLE;
          cur_nxt.prot = 1'b0;
        end else begin
          cur_nxt.cnt = cur_r.cnt + 32'h1;
        end
      end
      default: begin
        cur_nxt.st = ANVS_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Strobes reset high so that the memory sees no access while the
  // controller comes out of reset.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cur_r      <= '0;
      cur_r.st   <= ANVS_IDLE;
      cur_r.cs_n <= 1'b1;
      cur_r.we_n <= 1'b1;
      cur_r.oe_n <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every pin comes straight from the state register, so none of them
  // can glitch while the next state settles.
  assign busy_out          = cur_r.busy;
  assign done_out          = cur_r.done;
  assign rdata_out         = cur_r.rdata;
  assign protected_out     = cur_r.prot;
  assign chip_sel_n_out    = cur_r.cs_n;
  assign write_n_out       = cur_r.we_n;
  assign out_en_n_out      = cur_r.oe_n;
  assign address_lines_out = cur_r.addr;
  assign data_lines_out    = cur_r.wdata;
  assign data_lines_oe_out = cur_r.doe;
endmodule : anvs_host
`default_nettype wire

// ==== tb/anvs_host_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module anvs_host_props (
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        supply_fail_in,
  input wire logic        protected_out,
  input wire logic        chip_sel_n_out,
  input wire logic        write_n_out,
  input wire logic        out_en_n_out,
  input wire logic [17:0] address_lines_out,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // Two cycles low is 100 ns, which covers the slower grade as well.
  sequence wr_pulse_s;
    !write_n_out[*2] ##1 write_n_out;
  endsequence
  sequence rd_hold_s;
    (!chip_sel_n_out && !out_en_n_out)[*3];
  endsequence
  rd_no_write_a: assert property (!out_en_n_out |-> write_n_out)
    else $error("write strobe low in a read");
  wr_pulse_a: assert property (
    $fell(write_n_out) |-> !chip_sel_n_out throughout wr_pulse_s)
    else $error("write pulse too short");
  wr_data_a: assert property ($rose(write_n_out) |->
    data_lines_oe_out && $past(data_lines_oe_out, 2) && $stable(data_lines_out))
    else $error("write data not held");
  addr_hold_a: assert property (!chip_sel_n_out && $past(chip_sel_n_out) == 1'b0 |->
    $stable(address_lines_out))
    else $error("address moved while selected");
  rd_len_a: assert property ($fell(out_en_n_out) |-> rd_hold_s)
    else $error("read cycle too short");
  bus_clash_a: assert property (data_lines_oe_out |-> out_en_n_out)
    else $error("data driven while output strobe low");
  prot_idle_a: assert property (protected_out |-> chip_sel_n_out && !data_lines_oe_out)
    else $error("bus active while protected");
  prot_enter_a: assert property ($rose(supply_fail_in) |-> ##[1:12] protected_out)
    else $error("protection not entered");
  prot_hold_a: assert property ($fell(supply_fail_in) |-> protected_out[*6])
    else $error("protection left early");
  rec_gap_a: assert property ($rose(chip_sel_n_out) |=> chip_sel_n_out)
    else $error("no recovery gap after select rose");
endmodule : anvs_host_props
bind anvs_host anvs_host_props i_props (.ref_clk_in, .nrst_in, .supply_fail_in,
  .protected_out, .chip_sel_n_out, .write_n_out, .out_en_n_out, .address_lines_out,
  .data_lines_out, .data_lines_oe_out);
`default_nettype wire

// ==== tb/anvs_sram_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module anvs_sram_model (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        fail_in,
  input  wire logic        host_oe_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [7:0]  host_d_in,
  output wire logic [7:0]  dq_out
);
  logic [7:0] mem [logic [17:0]];
  logic [7:0] flt = 8'h5a;
  logic [7:0] dev;
  logic [7:0] dly;
  logic       wr_act = 1'b0;
  always @(posedge clk_in) flt <= ~flt;
  always @(cs_n_in or we_n_in) begin
    if (wr_act && !fail_in) mem[addr_in] = host_d_in;
    wr_act = !cs_n_in && !we_n_in;
  end
  // A floating bus toggles between 5a and a5 each clock, so stale data is not read as good unless the good byte is 5a or a5.
  always @* begin
    if (!cs_n_in && we_n_in && !oe_n_in && !fail_in) begin
      dev = mem.exists(addr_in) ? mem[addr_in] : 8'h00;
    end else begin
      dev = flt;
    end
  end
  always @(dev) dly <= #(slow_in ? 90 : 5) dev;
  assign dq_out = host_oe_in ? host_d_in : dly;
endmodule : anvs_sram_model
`default_nettype wire

// ==== tb/anvs_host_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module anvs_host_tb import anvs_pkg::*;;
  logic        ref_clk_in = 1'b0, nrst_in = 1'b0, req_in = 1'b0, req_wr_in = 1'b0;
  logic        supply_fail_in = 1'b0, slow = 1'b0;
  logic [17:0] req_addr_in = 18'h00000, address_lines_out;
  logic [7:0]  req_wdata_in = 8'h00, rdata_out, data_lines_out, data_lines_in;
  logic        busy_out, done_out, protected_out, chip_sel_n_out, write_n_out;
  logic        out_en_n_out, data_lines_oe_out;
  int          err_total = 0;
  int          n_tests = 0;
  logic [26:0] rows [6] = '{27'h40000a5, 27'h7ffff5a, 27'h40001ff,
                            27'h00000a5, 27'h3ffff5a, 27'h00001ff};
  always #25 ref_clk_in = ~ref_clk_in;
  anvs_host #(.TCER_CYC(10)) i_dut (.ref_clk_in, .nrst_in, .req_in, .req_wr_in, .req_addr_in,
    .req_wdata_in, .supply_fail_in, .busy_out, .done_out, .rdata_out, .protected_out,
    .chip_sel_n_out, .write_n_out, .out_en_n_out, .address_lines_out, .data_lines_out,
    .data_lines_oe_out, .data_lines_in);
  anvs_sram_model i_mem (.clk_in(ref_clk_in), .slow_in(slow), .cs_n_in(chip_sel_n_out),
    .we_n_in(write_n_out), .oe_n_in(out_en_n_out), .fail_in(supply_fail_in),
    .host_oe_in(data_lines_oe_out), .addr_in(address_lines_out), .host_d_in(data_lines_out),
    .dq_out(data_lines_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // A hold above one keeps the request up while busy, with changed data that must be ignored.
  task automatic access(input logic w, input logic [17:0] a, input logic [7:0] d, input int hold);
    @(negedge ref_clk_in);
    req_in = 1'b1;
    req_wr_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    repeat (hold) begin
      @(negedge ref_clk_in);
      req_wdata_in = ~d;
    end
    req_in = 1'b0;
    repeat (8) if (done_out !== 1'b1) @(negedge ref_clk_in);
    check({7'h00, done_out}, 8'h01);
    repeat (4) if (busy_out !== 1'b0) @(negedge ref_clk_in);
  endtask : access
  task automatic results();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      access(rows[i][26], rows[i][25:8], rows[i][7:0], 1);
      if (!rows[i][26]) check(rdata_out, rows[i][7:0]);
    end
    access(1'b1, 18'h00010, 8'h3c, 3);
    access(1'b0, 18'h00010, 8'h00, 1);
    check(rdata_out, 8'h3c);
    supply_fail_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    check({6'h00, protected_out, busy_out}, 8'h03);
    req_in = 1'b1;
    req_wr_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    req_in = 1'b0;
    check({7'h00, chip_sel_n_out}, 8'h01);
    supply_fail_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    check({7'h00, protected_out}, 8'h01);
    repeat (12) @(negedge ref_clk_in);
    check({7'h00, protected_out}, 8'h00);
    access(1'b0, 18'h00010, 8'h00, 1);
    check(rdata_out, 8'h3c);
    access(1'b1, 18'h00020, 8'h77, 3);
    nrst_in = 1'b0;
    #1;
    check({5'h00, chip_sel_n_out, write_n_out, data_lines_oe_out}, 8'h06);
    repeat (2) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    access(1'b0, 18'h00001, 8'h00, 1);
    check(rdata_out, 8'hff);
    results();
  end
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    err_total++;
    results();
  end
endmodule : anvs_host_tb
`default_nettype wire
